// File: rtl/wdg_pkg.sv
package wdg_pkg;
    // ==========================================================
    // Register indices and address width
    localparam logic [7:0] WDG_IDX_LIMP = 8'h0B;
    localparam logic [7:0] WDG_IDX_CFG = 8'h13;
    localparam logic [7:0] WDG_IDX_TMR = 8'h14;
    localparam logic [7:0] WDG_IDX_THR = 8'h15;
    localparam int WDG_AW = 8;

    // ==========================================================
    // Field positions
    localparam int WDG_LSEL_LSB = 3;
    localparam int WDG_LRST_BIT = 2;
    localparam int WDG_TMO_BIT = 6;
    localparam int WDG_PRE_LSB = 4;
    localparam int WDG_CODE_LSB = 5;
    localparam int WDG_ECNT_LSB = 1;
    localparam int WDG_ST_LIMP_BIT = 7;
    localparam int WDG_ST_SPI_BIT = 6;

    // ==========================================================
    // Reset values and encodings
    localparam logic [3:0] WDG_ECNT_RST = 4'h4;
    localparam logic [3:0] WDG_ECNT_MAX = 4'hF;
    localparam logic [3:0] WDG_ECNT_FIVE = 4'h5;
    localparam logic [3:0] WDG_ECNT_NINE = 4'h9;
    localparam logic [1:0] WDG_THR_EVERY = 2'h0;
    localparam logic [1:0] WDG_THR_FIVE = 2'h1;
    localparam logic [1:0] WDG_THR_NINE = 2'h2;
    localparam logic [1:0] WDG_LSEL_THIRD = 2'h0;
    localparam logic [1:0] WDG_LSEL_FIRST = 2'h1;
    localparam logic [1:0] WDG_LSEL_SW = 2'h2;
    localparam logic [1:0] WDG_GOOD_OFF = 2'h3;
    localparam logic [1:0] WDG_MODE_NORMAL = 2'h2;
    localparam logic [1:0] WDG_STRAP_GND = 2'h0;
    localparam logic [1:0] WDG_STRAP_VCC = 2'h2;
    localparam logic [1:0] WDG_RESP_OK = 2'h0;
    localparam logic [1:0] WDG_RESP_ERR = 2'h2;

    // ==========================================================
    // Timing
    localparam int WDG_CLK_NS = 50;
    localparam int WDG_MS_NS = 1000000;
    localparam int WDG_MS_CYC = WDG_MS_NS / WDG_CLK_NS;
    localparam int WDG_FILT_NS = 1000;
    localparam logic [7:0] WDG_FILT_CYC = 8'(WDG_FILT_NS / WDG_CLK_NS);
    localparam logic [3:0] WDG_PULSE_MS = 4'h2;

    typedef enum logic {WDG_IDLE, WDG_RUN} wdg_state_e;
endpackage : wdg_pkg

// File: rtl/wdg_window_watchdog.sv
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Strap or register control is latched from the select pin after reset.
// - Window mode by default; time-out only when register controlled.
// - Timer idles after entering normal mode until the first trigger.
// - Timer runs only in normal mode, held off in standby and sleep.
// - Limp-home output is off in standby and sleep.
// - Limp-home switches on when the error counter hits the trigger level.
// - Error counter increments on each missed window or bad trigger, saturating at 15.
// - Error counter decrements on each good trigger, saturating at zero.
// - Default and strap control pull the reset output low on every error.
// - Registers can move the reset threshold to fifth or ninth error.
// - Error count readable at bits 4 to 1 of register 0x14.
// - Error counter starts at four.
// - Interrupt output pulses low on every error event.
// - Strap pin picks the total window size from three levels.
// - Closed and open windows are each half the total window.
// - Both trigger edges count; glitches shorter than the filter rejected.
// - A full pulse counts as two triggers and so causes an error in window mode.
// - Registers 0x13 to 0x15 configure the watchdog under register control.
// - Bit 6 of register 0x13 selects time-out versus window mode.
// - Period in ms from the prescaler and three-bit timer code table.
// - In time-out mode any trigger before expiry is good.
// - Limp-home off after third good, first good, or software reset bit.
module wdg_window_watchdog #(
    parameter int MS_TICK_CYC = wdg_pkg::WDG_MS_CYC,
    parameter logic [15:0] WIN_GND_MS = 16'h0040,
    parameter logic [15:0] WIN_OPEN_MS = 16'h0080,
    parameter logic [15:0] WIN_VCC_MS = 16'h0100
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [wdg_pkg::WDG_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [wdg_pkg::WDG_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device pins and mode
    input wire logic control_select_chipsel,
    input wire logic [1:0] window_size_strap,
    input wire logic [1:0] device_mode,
    input wire logic watchdog_trigger_in,
    output logic watchdog_reset_out_n,
    output logic fault_notify_out_n,
    output logic limp_home_out
);
    import wdg_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic latched;
        logic cfg_spi;
        wdg_state_e state;
        logic [15:0] ms_div;
        logic [15:0] ms_cnt;
        logic trig_lvl;
        logic [7:0] filt_cnt;
        logic [3:0] err_cnt;
        logic [3:0] rst_cnt;
        logic [3:0] int_cnt;
        logic limp;
        logic [1:0] good_cnt;
        logic tmo_mode;
        logic [1:0] tick_divider_select;
        logic [2:0] period_code;
        logic [1:0] thr;
        logic [1:0] limp_sel;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } wdg_state_s;

    wdg_state_s q, n;
    logic ms_tick, normal, edge_ev, good, bad, miss, err, trip;
    logic wr_go, rd_go, sw_limp_off;
    logic [15:0] period, half;
    logic [3:0] err_nxt;
    logic [1:0] thr_eff;

    // ==========================================================
    // Helpers
    function automatic logic [15:0] wdg_period_ms(input logic [2:0] code, input logic [1:0] pre);
        logic [15:0] base;
        base = 16'h0000;
        case (code)
            3'h0: base = 16'h0004;
            3'h1: base = 16'h0020;
            3'h2: base = 16'h0080;
            3'h3: base = 16'h0100;
            3'h4: base = 16'h0200;
            3'h5: base = 16'h0800;
            default: base = 16'h2800;
        endcase
        if (code == 3'h3) begin
            case (pre)
                2'h0: wdg_period_ms = 16'h0100;
                2'h1: wdg_period_ms = 16'h0180;
                2'h2: wdg_period_ms = 16'h0200;
                default: wdg_period_ms = 16'h0300;
            endcase
        end else if (code >= 3'h6) begin
            wdg_period_ms = (code == 3'h6 && pre == 2'h1) ? 16'h4F10 : base;
        end else begin
            wdg_period_ms = 16'(base * ({14'h0000, pre} + 16'h0001));
        end
    endfunction : wdg_period_ms

    function automatic logic wdg_hit(input logic [7:0] a, input logic [7:0] idx);
        wdg_hit = (a[7:2] == idx[5:0]) && (a[1:0] == 2'h0) && (idx[7:6] == 2'h0);
    endfunction : wdg_hit

    // Handshake outputs
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
    assign rd_go = s_axi_arvalid && !q.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // Pin outputs
    assign watchdog_reset_out_n = (q.rst_cnt == 4'h0);
    assign fault_notify_out_n = (q.int_cnt == 4'h0);
    assign limp_home_out = q.limp && normal;
    assign normal = (device_mode == WDG_MODE_NORMAL);

    // ==========================================================
    // Next-state logic
    always_comb begin
        n = q;
        good = 1'b0;
        bad = 1'b0;
        miss = 1'b0;
        trip = 1'b0;
        edge_ev = 1'b0;
        sw_limp_off = 1'b0;
        // Select latched once after reset release
        if (!q.latched) begin
            n.latched = 1'b1;
            n.cfg_spi = control_select_chipsel;
        end
        // Millisecond tick
        ms_tick = (q.ms_div == 16'(MS_TICK_CYC - 1));
        n.ms_div = ms_tick ? 16'h0000 : q.ms_div + 16'h0001;
        // Glitch filter, either edge; pin level taken as idle level at the latch edge
        if (!q.latched) begin
            n.trig_lvl = watchdog_trigger_in;
            n.filt_cnt = 8'h00;
        end else if (watchdog_trigger_in != q.trig_lvl) begin
            n.filt_cnt = q.filt_cnt + 8'h01;
            if (q.filt_cnt + 8'h01 >= WDG_FILT_CYC) begin
                n.trig_lvl = watchdog_trigger_in;
                n.filt_cnt = 8'h00;
                edge_ev = 1'b1;
            end
        end else begin
            n.filt_cnt = 8'h00;
        end
        // Period selection
        if (q.cfg_spi) begin
            period = wdg_period_ms(q.period_code, q.tick_divider_select);
        end else if (window_size_strap == WDG_STRAP_GND) begin
            period = WIN_GND_MS;
        end else if (window_size_strap == WDG_STRAP_VCC) begin
            period = WIN_VCC_MS;
        end else begin
            period = WIN_OPEN_MS;
        end
        half = {1'b0, period[15:1]};
        // Window timer
        if (!normal) begin
            n.state = WDG_IDLE;
            n.ms_cnt = 16'h0000;
        end else if (edge_ev) begin
            n.ms_cnt = 16'h0000;
            if (q.state == WDG_IDLE) begin
                n.state = WDG_RUN;
            end else if (!(q.cfg_spi && q.tmo_mode) && q.ms_cnt < half) begin
                bad = 1'b1;
            end else begin
                good = 1'b1;
            end
        end else if (q.state == WDG_RUN && ms_tick) begin
            if (q.ms_cnt + 16'h0001 >= period) begin
                miss = 1'b1;
                n.ms_cnt = 16'h0000;
            end else begin
                n.ms_cnt = q.ms_cnt + 16'h0001;
            end
        end
        err = bad || miss;
        // Error counter
        err_nxt = (q.err_cnt == WDG_ECNT_MAX) ? q.err_cnt : q.err_cnt + 4'h1;
        if (err) begin
            n.err_cnt = err_nxt;
        end else if (good && q.err_cnt != 4'h0) begin
            n.err_cnt = q.err_cnt - 4'h1;
        end
        // Reset threshold
        thr_eff = q.cfg_spi ? q.thr : WDG_THR_EVERY;
        if (err) begin
            if (thr_eff == WDG_THR_FIVE) begin
                trip = (err_nxt >= WDG_ECNT_FIVE);
            end else if (thr_eff == WDG_THR_NINE) begin
                trip = (err_nxt >= WDG_ECNT_NINE);
            end else begin
                trip = 1'b1;
            end
        end
        // Output pulses
        if (trip) begin
            n.rst_cnt = WDG_PULSE_MS;
        end else if (ms_tick && q.rst_cnt != 4'h0) begin
            n.rst_cnt = q.rst_cnt - 4'h1;
        end
        if (err) begin
            n.int_cnt = WDG_PULSE_MS;
        end else if (ms_tick && q.int_cnt != 4'h0) begin
            n.int_cnt = q.int_cnt - 4'h1;
        end
        // Register writes
        if (wr_go) begin
            n.bvalid = 1'b1;
            n.bresp = WDG_RESP_OK;
            if (wdg_hit(s_axi_awaddr, WDG_IDX_LIMP) && s_axi_wstrb[0]) begin
                n.limp_sel = s_axi_wdata[WDG_LSEL_LSB+:2];
                sw_limp_off = s_axi_wdata[WDG_LRST_BIT];
            end else if (wdg_hit(s_axi_awaddr, WDG_IDX_CFG) && s_axi_wstrb[0]) begin
                n.tmo_mode = s_axi_wdata[WDG_TMO_BIT];
                n.tick_divider_select = s_axi_wdata[WDG_PRE_LSB+:2];
            end else if (wdg_hit(s_axi_awaddr, WDG_IDX_TMR) && s_axi_wstrb[0]) begin
                n.period_code = s_axi_wdata[WDG_CODE_LSB+:3];
            end else if (wdg_hit(s_axi_awaddr, WDG_IDX_THR) && s_axi_wstrb[0]) begin
                n.thr = s_axi_wdata[1:0];
            end else if (!(wdg_hit(s_axi_awaddr, WDG_IDX_LIMP) || wdg_hit(s_axi_awaddr, WDG_IDX_CFG)
                    || wdg_hit(s_axi_awaddr, WDG_IDX_TMR) || wdg_hit(s_axi_awaddr, WDG_IDX_THR))) begin
                n.bresp = WDG_RESP_ERR;
            end
        end else if (s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // Limp-home control
        if (!normal) begin
            n.limp = 1'b0;
            n.good_cnt = 2'h0;
        end else if (trip) begin
            n.limp = 1'b1;
            n.good_cnt = 2'h0;
        end else if (q.limp) begin
            if (q.limp_sel == WDG_LSEL_SW && sw_limp_off) begin
                n.limp = 1'b0;
            end else if (good && q.limp_sel == WDG_LSEL_FIRST) begin
                n.limp = 1'b0;
            end else if (good && q.limp_sel == WDG_LSEL_THIRD) begin
                n.good_cnt = q.good_cnt + 2'h1;
                n.limp = (q.good_cnt + 2'h1 != WDG_GOOD_OFF);
            end
        end
        // Register reads
        if (rd_go) begin
            n.rvalid = 1'b1;
            n.rresp = WDG_RESP_OK;
            n.rdata = 32'h0000_0000;
            if (wdg_hit(s_axi_araddr, WDG_IDX_LIMP)) begin
                n.rdata[WDG_LSEL_LSB+:2] = q.limp_sel;
            end else if (wdg_hit(s_axi_araddr, WDG_IDX_CFG)) begin
                n.rdata[WDG_TMO_BIT] = q.tmo_mode;
                n.rdata[WDG_PRE_LSB+:2] = q.tick_divider_select;
            end else if (wdg_hit(s_axi_araddr, WDG_IDX_TMR)) begin
                n.rdata[WDG_CODE_LSB+:3] = q.period_code;
                n.rdata[WDG_ECNT_LSB+:4] = q.err_cnt;
            end else if (wdg_hit(s_axi_araddr, WDG_IDX_THR)) begin
                n.rdata[1:0] = q.thr;
                n.rdata[WDG_ST_LIMP_BIT] = q.limp;
                n.rdata[WDG_ST_SPI_BIT] = q.cfg_spi;
            end else begin
                n.rresp = WDG_RESP_ERR;
            end
        end else if (s_axi_rready) begin
            n.rvalid = 1'b0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.state <= WDG_IDLE;
            q.err_cnt <= WDG_ECNT_RST;
            q.thr <= WDG_THR_EVERY;
            q.limp_sel <= WDG_LSEL_THIRD;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // Assertions
    a_sel_held: assert property (@(posedge aclk) disable iff (!aresetn)
        q.latched |=> $stable(q.cfg_spi)) else $error("select latch changed");
    a_idle_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !normal |=> q.state == WDG_IDLE && q.ms_cnt == 16'h0000) else $error("timer ran outside normal");
    a_limp_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        !normal |-> !limp_home_out) else $error("limp on outside normal");
    a_cnt_up: assert property (@(posedge aclk) disable iff (!aresetn)
        err && q.err_cnt < WDG_ECNT_MAX |=> q.err_cnt == $past(q.err_cnt) + 4'h1) else $error("no count up");
    a_cnt_floor: assert property (@(posedge aclk) disable iff (!aresetn)
        good && q.err_cnt == 4'h0 |=> q.err_cnt == 4'h0) else $error("counter wrapped");
    a_rst_every: assert property (@(posedge aclk) disable iff (!aresetn)
        err && !q.cfg_spi |=> !watchdog_reset_out_n) else $error("reset not pulled");
    a_notify_err: assert property (@(posedge aclk) disable iff (!aresetn)
        err |=> !fault_notify_out_n) else $error("notify not pulled");
    a_limp_trip: assert property (@(posedge aclk) disable iff (!aresetn)
        trip && normal |=> q.limp ##0 !watchdog_reset_out_n) else $error("limp not on");
    a_closed_bad: assert property (@(posedge aclk) disable iff (!aresetn)
        normal && edge_ev && q.state == WDG_RUN && !q.cfg_spi && q.ms_cnt < half |-> bad)
        else $error("closed window trigger accepted");
endmodule : wdg_window_watchdog

// File: sim/wdg_host_model.sv
`timescale 1ns/1ps
module wdg_host_model (
    // Clock
    input wire logic aclk,
    // Command from the bench: 0 toggle, 1 full pulse, 2 short glitch
    input wire logic cmd_go,
    input wire logic [1:0] cmd_kind,
    // Trigger line to the watchdog
    output logic watchdog_trigger_in
);
    logic [5:0] back_q = 6'h00;

    logic lvl_q = 1'b0;

    assign watchdog_trigger_in = lvl_q;

    // ==========================================================
    // Trigger line driver
    // Flip on command; pulse and glitch flip back after a delay
    always @(posedge aclk) begin
        if (cmd_go) begin
            lvl_q <= ~lvl_q;
            back_q <= (cmd_kind == 2'h1) ? 6'h28 : (cmd_kind == 2'h2) ? 6'h05 : 6'h00;
        end else if (back_q != 6'h00) begin
            back_q <= back_q - 6'h01;
            if (back_q == 6'h01) begin
                lvl_q <= ~lvl_q;
            end
        end
    end
endmodule : wdg_host_model

// File: sim/wdg_window_watchdog_tb.sv
`timescale 1ns/1ps
module wdg_window_watchdog_tb;
    import wdg_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} wdg_row_s;

    // ==========================================================
    // Signals
    localparam int MS = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic control_select_chipsel = 1'b0, cmd_go = 1'b0;
    logic [1:0] window_size_strap = 2'h0, device_mode = 2'h0, cmd_kind = 2'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, watchdog_trigger_in;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    logic watchdog_reset_out_n, fault_notify_out_n, limp_home_out;
    int miscompares = 0, cmp_count = 0;
    logic [1:0] sv [3] = '{2'h2, 2'h1, 2'h0};
    int em [3] = '{192, 96, 48}; // Three quarters of each window in ms
    // Register accesses: write data, or expected read data
    wdg_row_s rows [14] = '{
        '{1'b0, 8'h54, 32'h0000_0040, WDG_RESP_OK},
        '{1'b0, 8'h50, 32'h0000_0008, WDG_RESP_OK},
        '{1'b0, 8'h4C, 32'h0000_0000, WDG_RESP_OK},
        '{1'b1, 8'h4C, 32'h0000_0040, WDG_RESP_OK},
        '{1'b0, 8'h4C, 32'h0000_0040, WDG_RESP_OK},
        '{1'b1, 8'h50, 32'h0000_00FE, WDG_RESP_OK},
        '{1'b0, 8'h50, 32'h0000_00E8, WDG_RESP_OK},
        '{1'b1, 8'h50, 32'h0000_0020, WDG_RESP_OK},
        '{1'b1, 8'h54, 32'h0000_0001, WDG_RESP_OK},
        '{1'b0, 8'h54, 32'h0000_0041, WDG_RESP_OK},
        '{1'b1, 8'h2C, 32'h0000_0008, WDG_RESP_OK},
        '{1'b0, 8'h2C, 32'h0000_0008, WDG_RESP_OK},
        '{1'b1, 8'h00, 32'h0000_0000, WDG_RESP_ERR},
        '{1'b0, 8'h00, 32'h0000_0000, WDG_RESP_ERR}
    };

    // Clock, 50 ns period
    always #25 aclk = ~aclk;

    // ==========================================================
    // Design and host model
    wdg_window_watchdog #(.MS_TICK_CYC(MS), .WIN_GND_MS(16'h0040), .WIN_OPEN_MS(16'h0080),
        .WIN_VCC_MS(16'h0100)) dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .control_select_chipsel, .window_size_strap, .device_mode, .watchdog_trigger_in,
        .watchdog_reset_out_n, .fault_notify_out_n, .limp_home_out
    );
    wdg_host_model host_u (.aclk, .cmd_go, .cmd_kind, .watchdog_trigger_in);

    // ==========================================================
    // Tasks
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Bounded handshake wait: 0 awready, 1 bvalid, 2 arready, 3 rvalid
    // Answer sampled settled, before the edge that takes it
    task automatic hs(input int sel);
        int n;
        logic ok;
        n = 0;
        ok = 1'b0;
        while (!ok && n < 100) begin
            @(negedge aclk);
            ok = (sel == 0) ? (s_axi_awready === 1'b1) : (sel == 1) ? (s_axi_bvalid === 1'b1)
                : (sel == 2) ? (s_axi_arready === 1'b1) : (s_axi_rvalid === 1'b1);
            rd = s_axi_rdata;
            rs = (sel == 1) ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            n++;
        end
        if (!ok) begin
            chk(32'h0, 32'h1, "bus wait ran out");
            stop_test();
        end
    endtask : hs

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        hs(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        hs(1);
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        hs(2);
        s_axi_arvalid <= 1'b0;
        hs(3);
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic cnt(input logic [3:0] e);
        axi_rd(8'h50);
        chk({28'h0, rd[4:1]}, {28'h0, e}, "error count");
    endtask : cnt

    task automatic trig(input logic [1:0] k);
        @(posedge aclk);
        cmd_go <= 1'b1;
        cmd_kind <= k;
        @(posedge aclk);
        cmd_go <= 1'b0;
    endtask : trig

    // Watch outputs for n cycles; flags say whether a low is expected
    task automatic watch(input int n, input logic en, input logic er);
        logic sn, sr;
        sn = 1'b0;
        sr = 1'b0;
        repeat (n) begin
            @(negedge aclk);
            sn |= (fault_notify_out_n === 1'b0);
            sr |= (watchdog_reset_out_n === 1'b0);
        end
        chk({31'h0, sn}, {31'h0, en}, "notify low seen");
        chk({31'h0, sr}, {31'h0, er}, "reset low seen");
    endtask : watch

    task automatic do_reset(input logic sel, input logic [1:0] st);
        @(posedge aclk);
        aresetn <= 1'b0;
        control_select_chipsel <= sel;
        window_size_strap <= st;
        device_mode <= 2'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        control_select_chipsel <= ~sel;
        device_mode <= WDG_MODE_NORMAL;
    endtask : do_reset

    // ==========================================================
    // Main sequence
    initial begin
        do_reset(1'b1, 2'h1);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_wr(rows[i].a, rows[i].d);
            end else begin
                axi_rd(rows[i].a);
                chk(rd, rows[i].d, "read data");
            end
            chk({30'h0, rs}, {30'h0, rows[i].r}, "response");
        end
        // Write with byte strobe low is acknowledged and ignored
        s_axi_wstrb <= 4'h0;
        axi_wr(8'h54, 32'h0000_0002);
        chk({30'h0, rs}, {30'h0, WDG_RESP_OK}, "strobe-less response");
        s_axi_wstrb <= 4'hF;
        axi_rd(8'h54);
        chk(rd, 32'h0000_0041, "strobe-less write ignored");
        $display("test registers done");
        // Time-out mode, 32 ms period, fifth-error threshold
        trig(2'h0);
        repeat (30) @(posedge aclk);
        trig(2'h0);
        watch(560, 1'b0, 1'b0);
        cnt(4'h3);
        watch(300, 1'b1, 1'b0);
        cnt(4'h4);
        watch(600, 1'b1, 1'b1);
        cnt(4'h5);
        chk({31'h0, limp_home_out}, 32'h1, "limp on at trip");
        // First good trigger releases limp-home, next miss trips again
        trig(2'h0);
        watch(60, 1'b0, 1'b0);
        chk({31'h0, limp_home_out}, 32'h0, "limp off after first good");
        cnt(4'h4);
        watch(700, 1'b1, 1'b1);
        chk({31'h0, limp_home_out}, 32'h1, "limp on at second trip");
        @(posedge aclk);
        device_mode <= 2'h0;
        repeat (3) @(posedge aclk);
        chk({31'h0, limp_home_out}, 32'h0, "limp off in standby");
        repeat (60) @(posedge aclk);
        watch(1400, 1'b0, 1'b0);
        cnt(4'h5);
        device_mode <= WDG_MODE_NORMAL;
        watch(1400, 1'b0, 1'b0);
        trig(2'h0);
        repeat (30) @(posedge aclk);
        trig(2'h0);
        watch(60, 1'b0, 1'b0);
        chk({31'h0, limp_home_out}, 32'h0, "limp off after good");
        cnt(4'h4);
        $display("test time-out done");
        // Strap control: service at three quarters of each window
        for (int i = 0; i < 3; i++) begin
            do_reset(1'b0, sv[i]);
            axi_wr(8'h4C, 32'h0000_0040);
            axi_rd(8'h54);
            chk({31'h0, rd[6]}, 32'h0, "strap select latched");
            trig(2'h0);
            repeat (em[i] * MS) @(posedge aclk);
            trig(2'h0);
            watch(60, 1'b0, 1'b0);
            cnt(4'h3);
        end
        $display("test strap windows done");
        // Pulse, glitch and missed window on the 64 ms window
        repeat (40) @(posedge aclk);
        trig(2'h1);
        watch(120, 1'b1, 1'b1);
        cnt(4'h5);
        trig(2'h2);
        watch(200, 1'b0, 1'b0);
        watch(1200, 1'b1, 1'b1);
        cnt(4'h6);
        $display("test strap faults done");
        // Register control, window mode, 4 ms window, ninth-error threshold
        do_reset(1'b1, 2'h1);
        axi_wr(8'h54, 32'h0000_0002);
        trig(2'h0);
        watch(300, 1'b1, 1'b0);
        cnt(4'h7);
        watch(80, 1'b1, 1'b0);
        watch(60, 1'b1, 1'b1);
        cnt(4'h9);
        $display("test ninth threshold done");
        stop_test();
    end
endmodule : wdg_window_watchdog_tb
